// [rtl/mmsas_pkg.sv]
/*
 Shared constants and carriers for the mode select and address space block.
 Assumes one 25 MHz clock and an asynchronous active-low reset.
*/
package mmsas_pkg;

	localparam int unsigned MMSAS_PA_W = 8;
	localparam int unsigned MMSAS_PB_W = 8;
	localparam int unsigned MMSAS_PC_W = 4;
	localparam int unsigned MMSAS_IO_W = 20;
	localparam int unsigned MMSAS_PROG_AW = 12;
	localparam int unsigned MMSAS_DATA_AW = 8;
	localparam int unsigned MMSAS_STACK_AW = 2;
	localparam int unsigned MMSAS_TMR_W = 8;
	localparam int unsigned MMSAS_PRE_W = 7;

	// Data space map
	localparam logic [7:0] MMSAS_ADR_PORT_A = 8'h00;
	localparam logic [7:0] MMSAS_ADR_PORT_B = 8'h01;
	localparam logic [7:0] MMSAS_ADR_PORT_C = 8'h02;
	localparam logic [7:0] MMSAS_ADR_DDR_A = 8'h04;
	localparam logic [7:0] MMSAS_ADR_DDR_B = 8'h05;
	localparam logic [7:0] MMSAS_ADR_DDR_C = 8'h06;
	localparam logic [7:0] MMSAS_ADR_TSC = 8'h09;
	localparam logic [7:0] MMSAS_ADR_ROM_LO = 8'h0a;
	localparam logic [7:0] MMSAS_ADR_ROM_HI = 8'h51;
	localparam logic [7:0] MMSAS_ADR_RAM_LO = 8'h80;
	localparam logic [7:0] MMSAS_ADR_RAM_HI = 8'hfb;
	localparam logic [7:0] MMSAS_ADR_PRE = 8'hfc;
	localparam logic [7:0] MMSAS_ADR_CNT = 8'hfd;
	localparam logic [7:0] MMSAS_ADR_ACC = 8'hff;
	localparam logic [7:0] MMSAS_ADR_XP = 8'h80;
	localparam logic [7:0] MMSAS_ADR_YP = 8'h81;

	// Program space map
	localparam logic [11:0] MMSAS_PRG_SC_LO = 12'h000;
	localparam logic [11:0] MMSAS_PRG_SC_HI = 12'h15f;
	localparam logic [11:0] MMSAS_PRG_USR_LO = 12'h160;
	localparam logic [11:0] MMSAS_PRG_USR_HI = 12'h7f7;
	localparam logic [11:0] MMSAS_PRG_VEC_LO = 12'h7f8;
	localparam logic [11:0] MMSAS_PRG_VEC_HI = 12'h7ff;
	localparam logic [11:0] MMSAS_PRG_RESET = 12'h160;

	localparam logic [1:0] MMSAS_DIV1 = 2'h0;
	localparam logic [1:0] MMSAS_DIV2 = 2'h1;
	localparam logic [1:0] MMSAS_DIV4 = 2'h2;

	typedef enum logic [1:0] {
		MMSAS_SINGLE_CHIP,
		MMSAS_SELF_CHECK,
		MMSAS_ROM_VERIFY
	} mmsas_mode_t;

	typedef enum logic [1:0] {
		MMSAS_TMR_OUT,
		MMSAS_TMR_GATE,
		MMSAS_TMR_CLK
	} mmsas_tmode_t;

	typedef enum logic [1:0] {
		MMSAS_RUN_RESET,
		MMSAS_RUN_ACTIVE
	} mmsas_run_t;

	typedef enum logic [1:0] {
		MMSAS_REG_NONE,
		MMSAS_REG_IO,
		MMSAS_REG_TMR,
		MMSAS_REG_MEM
	} mmsas_kind_t;

	// Data space access from the core
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mmsas_dreq_t;

	// Manufacturing and mask options
	typedef struct packed {
		logic [1:0] clk_div;
		logic irq_level;
		logic rom_protect;
		logic [1:0] code_self_check;
		logic [1:0] code_rom_verify;
	} mmsas_opt_t;

endpackage

// [rtl/mmsas_top.sv]
/*
 Mode selection, address space decode, ports, timer pin and interrupt pin.
 Assumes a core that issues data and program accesses and stack pushes/pops.
*/
`timescale 1ns/100ps
module mmsas_top import mmsas_pkg::*; #(
	parameter int unsigned STACK_DEPTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Pins
	input wire logic mode_select_pin,
	input wire logic irq_b,
	input wire logic [MMSAS_IO_W-1:0] io_in,
	output logic [MMSAS_IO_W-1:0] io_out,
	output logic [MMSAS_IO_W-1:0] io_oe,
	input wire logic timer_in,
	output logic timer_out,
	output logic timer_oe,
	// Options
	input wire mmsas_opt_t opt,
	input wire mmsas_tmode_t tmr_mode,
	// Core side
	input wire mmsas_dreq_t dreq,
	input wire logic [MMSAS_PROG_AW-1:0] pc,
	input wire logic [7:0] prog_rdata,
	input wire logic test_read,
	input wire logic push,
	input wire logic pop,
	input wire logic [MMSAS_PROG_AW-1:0] push_addr,
	output logic [7:0] drdata,
	output logic [MMSAS_PROG_AW-1:0] pop_addr,
	output logic [MMSAS_PROG_AW-1:0] pc_start,
	output logic core_restart,
	output logic clk_en,
	output logic irq_req,
	output logic [7:0] rom_dump,
	output logic prog_region_user,
	output mmsas_mode_t mode
);

	localparam int unsigned RAM_N = int'(MMSAS_ADR_RAM_HI) - int'(MMSAS_ADR_RAM_LO) + 1;

	typedef struct packed {
		mmsas_run_t run;
		mmsas_mode_t mode;
		logic restart;
		logic [1:0] div_cnt;
		logic en;
		logic [2:0] irq_s;
		logic irq_req;
		logic [2:0] tin_s;
		logic [MMSAS_IO_W-1:0] io_data;
		logic [MMSAS_IO_W-1:0] io_ddr;
		logic [MMSAS_PRE_W-1:0] pre;
		logic [MMSAS_TMR_W-1:0] cnt;
		logic tout;
		logic [7:0] rdata;
		logic [7:0] dump;
		logic user;
		logic [MMSAS_PROG_AW-1:0] pop_addr;
		logic [STACK_DEPTH-1:0][MMSAS_PROG_AW-1:0] stack;
		logic [$clog2(STACK_DEPTH)-1:0] sp;
		logic [RAM_N-1:0][7:0] ram;
		logic [7:0] acc;
	} mmsas_state_t;

	mmsas_state_t s_reg;
	mmsas_state_t s_next;
	logic [1:0] mode_lines;
	logic tin_edge;
	logic tick;

	// Data space region decode
	function automatic mmsas_kind_t kind_of(input logic [7:0] a);
		if (a <= MMSAS_ADR_PORT_C || (a >= MMSAS_ADR_DDR_A && a <= MMSAS_ADR_DDR_C) ||
			a == MMSAS_ADR_TSC) begin
			kind_of = MMSAS_REG_IO;
		end else if (a == MMSAS_ADR_PRE || a == MMSAS_ADR_CNT) begin
			kind_of = MMSAS_REG_TMR;
		end else if ((a >= MMSAS_ADR_RAM_LO && a <= MMSAS_ADR_RAM_HI) || a == MMSAS_ADR_ACC) begin
			kind_of = MMSAS_REG_MEM;
		end else begin
			kind_of = MMSAS_REG_NONE;
		end
	endfunction

	// Mode decode of port A lines 6 and 7
	function automatic mmsas_mode_t decode_mode(input logic [1:0] c, input mmsas_opt_t o);
		if (c == o.code_self_check) begin
			decode_mode = MMSAS_SELF_CHECK;
		end else if (c == o.code_rom_verify) begin
			decode_mode = MMSAS_ROM_VERIFY;
		end else begin
			decode_mode = MMSAS_SINGLE_CHIP;
		end
	endfunction

	// Port A occupies io 7:0, B 15:8, C 19:16
	function automatic logic [MMSAS_IO_W-1:0] port_mask(input logic [1:0] p);
		case (p)
			2'h0: port_mask = 20'h000ff;
			2'h1: port_mask = 20'h0ff00;
			default: port_mask = 20'hf0000;
		endcase
	endfunction

	// Port registers are still cleared at reset exit, so the pins are read
	assign mode_lines = io_in[7:6];
	assign tin_edge = s_reg.tin_s[1] & ~s_reg.tin_s[2];
	assign tick = (tmr_mode == MMSAS_TMR_CLK) ? tin_edge :
		(tmr_mode == MMSAS_TMR_GATE) ? (s_reg.en & s_reg.tin_s[2]) : s_reg.en;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [MMSAS_IO_W-1:0] m;
		logic [1:0] pidx;
		logic [19:0] ext;
		logic [6:0] ridx;
		ridx = '0;
		m = '0;
		pidx = 2'h0;
		ext = '0;
		s_next = s_reg;
		s_next.restart = 1'b0;
		s_next.irq_s = {s_reg.irq_s[1:0], ~irq_b};
		s_next.tin_s = {s_reg.tin_s[1:0], timer_in};

		// Pin inputs of port lines sampled into data when they are inputs
		s_next.io_data = (s_reg.io_data & s_reg.io_ddr) | (io_in & ~s_reg.io_ddr);

		case (s_reg.run)
			MMSAS_RUN_RESET: begin
				if (mode_select_pin) begin
					s_next.mode = decode_mode(mode_lines, opt);
				end else begin
					s_next.mode = MMSAS_SINGLE_CHIP;
				end
				s_next.restart = 1'b1;
				s_next.run = MMSAS_RUN_ACTIVE;
			end
			MMSAS_RUN_ACTIVE: begin
			end
			default: s_next.run = MMSAS_RUN_RESET;
		endcase

		// Oscillator divide option
		s_next.div_cnt = s_reg.div_cnt + 2'h1;
		case (opt.clk_div)
			MMSAS_DIV1: s_next.en = 1'b1;
			MMSAS_DIV2: s_next.en = s_reg.div_cnt[0];
			MMSAS_DIV4: s_next.en = &s_reg.div_cnt;
			default: s_next.en = 1'b1;
		endcase

		// Interrupt sensitivity option
		if (opt.irq_level) begin
			s_next.irq_req = s_reg.irq_s[2];
		end else begin
			s_next.irq_req = s_reg.irq_s[1] & ~s_reg.irq_s[2];
		end

		// Prescaler and counter
		s_next.tout = 1'b0;
		if (tick) begin
			s_next.pre = s_reg.pre + 7'h01;
			if (&s_reg.pre) begin
				s_next.cnt = s_reg.cnt - 8'h01;
				s_next.tout = (s_reg.cnt == 8'h01);
			end
		end

		// Data space accesses
		s_next.rdata = 8'h00;
		pidx = dreq.addr[1:0];
		m = port_mask(pidx);
		ext = (pidx == 2'h0) ? 20'h00001 : (pidx == 2'h1) ? 20'h00100 : 20'h10000;
		case (kind_of(dreq.addr))
			MMSAS_REG_IO: begin
				if (dreq.addr <= MMSAS_ADR_PORT_C) begin
					s_next.rdata = 8'((s_reg.io_data & m) / ext);
					if (dreq.wr) begin
						s_next.io_data = (s_next.io_data & ~m) | ((20'(dreq.wdata) * ext) & m);
					end
				end else if (dreq.addr != MMSAS_ADR_TSC) begin
					pidx = dreq.addr[1:0] - 2'h0;
					s_next.rdata = 8'((s_reg.io_ddr & m) / ext);
					if (dreq.wr) begin
						s_next.io_ddr = (s_reg.io_ddr & ~m) | ((20'(dreq.wdata) * ext) & m);
					end
				end else begin
					s_next.rdata = {7'h00, s_reg.tout};
				end
			end
			MMSAS_REG_TMR: begin
				s_next.rdata = (dreq.addr == MMSAS_ADR_CNT) ? s_reg.cnt : {1'b0, s_reg.pre};
				if (dreq.wr && dreq.addr == MMSAS_ADR_CNT) begin
					s_next.cnt = dreq.wdata;
				end
			end
			MMSAS_REG_MEM: begin
				if (dreq.addr == MMSAS_ADR_ACC) begin
					s_next.rdata = s_reg.acc;
					if (dreq.wr) begin
						s_next.acc = dreq.wdata;
					end
				end else begin
					ridx = 7'(dreq.addr - MMSAS_ADR_RAM_LO);
					s_next.rdata = s_reg.ram[ridx];
					if (dreq.wr) begin
						s_next.ram[ridx] = dreq.wdata;
					end
				end
			end
			default: begin
			end
		endcase

		// Stack space reached only by push and pop
		if (push) begin
			s_next.stack[s_reg.sp] = push_addr;
			s_next.sp = s_reg.sp + 1'b1;
		end else if (pop) begin
			s_next.pop_addr = s_reg.stack[s_reg.sp - 1'b1];
			s_next.sp = s_reg.sp - 1'b1;
		end

		// Program ROM dump in test modes
		s_next.user = (pc >= MMSAS_PRG_USR_LO && pc <= MMSAS_PRG_VEC_HI);
		if (test_read && s_reg.mode != MMSAS_SINGLE_CHIP && !opt.rom_protect) begin
			s_next.dump = prog_rdata;
		end else begin
			s_next.dump = 8'h00;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign io_out = s_reg.io_data;
	assign io_oe = s_reg.io_ddr;
	assign timer_out = s_reg.tout;
	assign timer_oe = (tmr_mode == MMSAS_TMR_OUT);
	assign drdata = s_reg.rdata;
	assign pop_addr = s_reg.pop_addr;
	assign pc_start = MMSAS_PRG_RESET;
	assign core_restart = s_reg.restart;
	assign clk_en = s_reg.en;
	assign irq_req = s_reg.irq_req;
	assign rom_dump = s_reg.dump;
	assign prog_region_user = s_reg.user;
	assign mode = s_reg.mode;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	mode_low_single_a: assert property (
		s_reg.run == MMSAS_RUN_RESET && !mode_select_pin |=> mode == MMSAS_SINGLE_CHIP)
		else $error("mode pin low did not give single chip");
	mode_high_decode_a: assert property (
		s_reg.run == MMSAS_RUN_RESET && mode_select_pin |=>
		mode == decode_mode($past(mode_lines), $past(opt)))
		else $error("mode decode not latched");
	restart_once_a: assert property (
		core_restart |=> !core_restart)
		else $error("restart pulse too long");
	protect_dump_a: assert property (
		$past(opt.rom_protect) |-> rom_dump == 8'h00)
		else $error("protected rom output");
	level_irq_a: assert property (
		opt.irq_level && !irq_b [*5] |-> irq_req)
		else $error("level interrupt lost");
	ddr_write_a: assert property (
		dreq.wr && dreq.addr == MMSAS_ADR_DDR_A |=> io_oe[7:0] == $past(dreq.wdata))
		else $error("direction write lost");
	div1_enable_a: assert property (
		opt.clk_div == MMSAS_DIV1 [*2] |-> clk_en)
		else $error("divide by one enable missing");
	timer_pin_a: assert property (
		timer_out |-> $past(s_reg.cnt) == 8'h01)
		else $error("timeout without count end");

	restart_c: cover property (core_restart && mode == MMSAS_SELF_CHECK);
	dump_c: cover property (rom_dump != 8'h00);
	timeout_c: cover property (timer_out);
	irq_c: cover property (irq_req && !opt.irq_level);

endmodule

// [verif/mmsas_board.sv]
/*
 Board model around the port pins of the mode select block.
 Assumes the bench sets the level that the board puts on each line.
*/
`timescale 1ns/100ps
module mmsas_board import mmsas_pkg::*; (
	// Board levels
	input wire logic [MMSAS_IO_W-1:0] ext_level,
	// Device pins
	input wire logic [MMSAS_IO_W-1:0] io_out,
	input wire logic [MMSAS_IO_W-1:0] io_oe,
	output logic [MMSAS_IO_W-1:0] io_in
);
	// Driven lines show the device level, released ones the board level
	assign io_in = (io_oe & io_out) | (~io_oe & ext_level);
endmodule

// [verif/mmsas_top_tb.sv]
/*
 Self-checking bench for the mode select and address space block.
 Assumes the board model resolves the port lines.
*/
`timescale 1ns/100ps
module mmsas_top_tb import mmsas_pkg::*; ();
	logic clock, rst_b, mode_select_pin, irq_b, timer_in, test_read, push, pop;
	logic timer_out, timer_oe, core_restart, clk_en, irq_req, prog_region_user;
	logic [MMSAS_IO_W-1:0] io_in, io_out, io_oe, ext;
	logic [11:0] pc, push_addr, pop_addr, pc_start;
	logic [7:0] prog_rdata, drdata, rom_dump, rd;
	mmsas_opt_t opt;
	mmsas_tmode_t tmr_mode;
	mmsas_dreq_t dreq;
	mmsas_mode_t mode;
	int n_mismatch, samples_checked, k;
	logic [7:0] k_tab [3] = '{8'h80, 8'hfb, 8'hff};
	logic [11:0] pc_tab [6] = '{12'h15f, 12'h160, 12'h7f7, 12'h7f8, 12'h7ff, 12'h000};
	mmsas_top u_mmsas_top (.clock(clock), .rst_b(rst_b), .mode_select_pin(mode_select_pin),
		.irq_b(irq_b), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .timer_in(timer_in),
		.timer_out(timer_out), .timer_oe(timer_oe), .opt(opt), .tmr_mode(tmr_mode),
		.dreq(dreq), .pc(pc), .prog_rdata(prog_rdata), .test_read(test_read), .push(push),
		.pop(pop), .push_addr(push_addr), .drdata(drdata), .pop_addr(pop_addr),
		.pc_start(pc_start), .core_restart(core_restart), .clk_en(clk_en),
		.irq_req(irq_req), .rom_dump(rom_dump), .prog_region_user(prog_region_user),
		.mode(mode));
	mmsas_board u_mmsas_board (.ext_level(ext), .io_out(io_out), .io_oe(io_oe),
		.io_in(io_in));
	// ----------------------------------------
	// Clock and tasks
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic do_reset(input logic mp, input logic [1:0] code, input mmsas_mode_t exp);
		@(negedge clock);
		rst_b = 1'b0;
		mode_select_pin = mp;
		ext[7:6] = code;
		repeat (20) @(negedge clock);
		rst_b = 1'b1;
		k = 0;
		repeat (4) begin
			@(negedge clock);
			k += int'(core_restart);
		end
		chk("restart", 12'(k), 12'h001);
		chk("mode", 12'(mode), 12'(exp));
	endtask
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		@(negedge clock);
		dreq = '{wr, a, wd};
		@(negedge clock);
		dreq = '{1'b0, 8'h03, 8'h00};
		rd = drdata;
	endtask
	task automatic dump(input logic p, input logic [7:0] exp);
		@(negedge clock);
		opt.rom_protect = p;
		test_read = 1'b1;
		@(negedge clock);
		test_read = 1'b0;
		chk("rom_dump", 12'(rom_dump), 12'(exp));
	endtask
	task automatic stk(input logic pu, input logic [11:0] a);
		@(negedge clock);
		push = pu;
		pop = ~pu;
		push_addr = a;
		@(negedge clock);
		push = 1'b0;
		pop = 1'b0;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		rst_b = 1'b0; mode_select_pin = 1'b0; irq_b = 1'b1; timer_in = 1'b0;
		test_read = 1'b0; push = 1'b0; pop = 1'b0; pc = 12'h000; push_addr = 12'h000;
		prog_rdata = 8'h3c; ext = 20'h5a5a5; tmr_mode = MMSAS_TMR_OUT;
		opt = '{MMSAS_DIV1, 1'b1, 1'b0, 2'h3, 2'h0};
		dreq = '{1'b0, 8'h03, 8'h00};
		n_mismatch = 0; samples_checked = 0;
		do_reset(1'b0, 2'h3, MMSAS_SINGLE_CHIP);
		dump(1'b0, 8'h00);
		do_reset(1'b1, 2'h1, MMSAS_SINGLE_CHIP);
		do_reset(1'b1, 2'h2, MMSAS_SINGLE_CHIP);
		do_reset(1'b1, 2'h0, MMSAS_ROM_VERIFY);
		do_reset(1'b1, 2'h3, MMSAS_SELF_CHECK);
		chk("pc_start", pc_start, 12'h160);
		dump(1'b0, 8'h3c);
		dump(1'b1, 8'h00);
		acc(1'b1, MMSAS_ADR_DDR_A, 8'hf0);
		chk("oe_a", 12'(io_oe[7:0]), 12'h0f0);
		acc(1'b1, MMSAS_ADR_DDR_C, 8'h0a);
		chk("oe_c", 12'(io_oe[19:16]), 12'h00a);
		acc(1'b1, MMSAS_ADR_PORT_B, 8'h96);
		chk("out_b", 12'(io_out[15:8]), 12'h096);
		acc(1'b1, MMSAS_ADR_PORT_A, 8'h30);
		acc(1'b0, MMSAS_ADR_PORT_A, 8'h00);
		chk("port_a", 12'(rd), 12'h035);
		acc(1'b0, MMSAS_ADR_PORT_C, 8'h00);
		chk("port_c", 12'(rd[3:0]), 12'h005);
		foreach (k_tab[i]) begin
			acc(1'b1, k_tab[i], 8'h5c ^ k_tab[i]);
			acc(1'b0, k_tab[i], 8'h00);
			chk("data", 12'(rd), 12'(8'h5c ^ k_tab[i]));
		end
		acc(1'b1, 8'h03, 8'h77);
		acc(1'b0, 8'h03, 8'h00);
		chk("unmapped", 12'(rd), 12'h000);
		stk(1'b1, 12'h123);
		stk(1'b1, 12'h456);
		stk(1'b0, 12'h000);
		chk("pop1", pop_addr, 12'h456);
		stk(1'b0, 12'h000);
		chk("pop2", pop_addr, 12'h123);
		foreach (pc_tab[i]) begin
			@(negedge clock);
			pc = pc_tab[i];
			@(negedge clock);
			chk("region", 12'(prog_region_user), 12'(i > 0 && i < 5));
		end
		chk("toe_out", 12'(timer_oe), 12'h001);
		tmr_mode = MMSAS_TMR_GATE;
		#1 chk("toe_gate", 12'(timer_oe), 12'h000);
		tmr_mode = MMSAS_TMR_CLK;
		#1 chk("toe_clk", 12'(timer_oe), 12'h000);
		for (int d = 0; d < 3; d++) begin
			opt.clk_div = 2'(d);
			repeat (4) @(negedge clock);
			k = 0;
			repeat (8) begin
				@(negedge clock);
				k += int'(clk_en);
			end
			chk("clk_en", 12'(k), 12'(8 >> d));
		end
		chk("irq_idle", 12'(irq_req), 12'h000);
		irq_b = 1'b0;
		#7;
		k = 0;
		while (irq_req !== 1'b1 && k < 10) begin
			@(negedge clock);
			k++;
		end
		chk("irq_req", 12'(irq_req), 12'h001);
		tally_and_finish();
	end
endmodule
